// ===== hw/sdlc_top.v
// Lane analog control register bank with an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_consts.vh"

module sdlc_top (
    // Clock and resets
    input  wire                                 clk_sys,
    input  wire                                 resetn,
    input  wire                                 sticky_resetn,
    // AHB-Lite slave
    input  wire                                 hsel,
    input  wire [31:0]                          haddr,
    input  wire [1:0]                           htrans,
    input  wire                                 hwrite,
    input  wire [2:0]                           hsize,
    input  wire [31:0]                          hwdata,
    input  wire                                 hready,
    output reg  [31:0]                          hrdata_reg,
    output reg                                  hreadyout_reg,
    output reg                                  hresp_reg,
    // Per-lane transmit controls
    output reg  [`SDLC_LANES*4-1:0]             lane_ls_level_reg,
    output reg  [`SDLC_LANES-1:0]               lane_ls_use_reg,
    output reg  [`SDLC_LANES*3-1:0]             lane_fine_deemph_reg,
    output reg  [`SDLC_LANES-1:0]               lane_fine_deemph_use_reg,
    // Per-lane receiver equalizer controls
    output reg  [`SDLC_LANES*3-1:0]             lane_rx_eq_zero_reg,
    output reg  [`SDLC_LANES*3-1:0]             lane_rx_eq_boost_reg,
    output reg  [`SDLC_LANES-1:0]               lane_rx_eq_en_reg
);

    // Bus states
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_WAIT1 = 3'h2;
    localparam [2:0] ST_WAIT2 = 3'h4;

    reg  [2:0]                          state_reg;
    reg  [2:0]                          state_next;
    reg                                 wr_pend_reg;
    reg  [`SDLC_ADDR_W-1:0]             addr_reg;
    reg  [`SDLC_LANE_W-1:0]             lane_select_reg;
    reg  [`SDLC_PC_W-1:0]               port_cfg_reg;
    reg  [31:0]                         rdata_mux;

    wire                                take;
    wire                                take_rd;
    wire                                take_wr;
    wire                                wr_tx;
    wire                                wr_rx;
    wire                                wr_xc;
    wire                                wr_pc;
    wire [`SDLC_ENT_W-1:0]              wr_data;
    wire [`SDLC_ENT_W-1:0]              rd_ent;
    wire [`SDLC_LANES*`SDLC_ENT_W-1:0]  all_q;
    wire                                deemph_6db;
    wire                                low_swing;
    wire                                gen2;

    // Address phase accepted only while the bus is ready
    assign take    = hsel && hready && (htrans == `SDLC_HTRANS_NONSEQ);
    assign take_rd = take && !hwrite;
    assign take_wr = take && hwrite;

    // Write commit in the data phase of a write
    assign wr_tx = wr_pend_reg && (addr_reg == `SDLC_OFF_TX_DRIVE);
    assign wr_rx = wr_pend_reg && (addr_reg == `SDLC_OFF_RX_EQ);
    assign wr_xc = wr_pend_reg && (addr_reg == `SDLC_OFF_XCVR_CTL);
    assign wr_pc = wr_pend_reg && (addr_reg == `SDLC_OFF_PORT_CFG);

    assign wr_data = {hwdata[`SDLC_TX_LSG2], hwdata[`SDLC_TX_LSG1],
                      hwdata[`SDLC_TX_FINE], hwdata[`SDLC_RX_BOOST],
                      hwdata[`SDLC_RX_ZERO]};

    // Steered to the selected lane only
    sdlc_lane_mem u_mem (
        .clk_sys       (clk_sys),
        .sticky_resetn (sticky_resetn),
        .wr_lane       (lane_select_reg),
        .wr_tx         (wr_tx),
        .wr_rx         (wr_rx),
        .wr_data       (wr_data),
        .rd_lane       (lane_select_reg),
        .rd_data_reg   (rd_ent),
        .all_q         (all_q)
    );

    // Bus state machine; reads wait two cycles so a write in flight
    // and a lane select change are both seen by the read port
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                state_next = take_rd ? ST_WAIT1 : ST_IDLE;
            end
            ST_WAIT1: begin
                state_next = ST_WAIT2;
            end
            ST_WAIT2: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg     <= ST_IDLE;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= `SDLC_HRESP_OKAY;
            wr_pend_reg   <= 1'b0;
            addr_reg      <= {`SDLC_ADDR_W{1'b0}};
        end else begin
            state_reg     <= state_next;
            hreadyout_reg <= (state_next == ST_IDLE);
            hresp_reg     <= `SDLC_HRESP_OKAY;
            wr_pend_reg   <= take_wr;
            if (take) begin
                addr_reg <= haddr[`SDLC_ADDR_W-1:0];
            end
        end
    end

    // Read data mux; unmapped offsets and reserved bits read as zero
    always @* begin
        case (addr_reg)
            `SDLC_OFF_TX_DRIVE: begin
                rdata_mux = {rd_ent[`SDLC_ENT_LSG2], rd_ent[`SDLC_ENT_LSG1],
                             rd_ent[`SDLC_ENT_FINE], `SDLC_TX_LOW_ZERO};
            end
            `SDLC_OFF_RX_EQ: begin
                rdata_mux = {`SDLC_RX_HIGH_ZERO, rd_ent[`SDLC_ENT_RX]};
            end
            `SDLC_OFF_XCVR_CTL: begin
                rdata_mux = {28'h0000000, lane_select_reg};
            end
            `SDLC_OFF_PORT_CFG: begin
                rdata_mux = {29'h0000000, port_cfg_reg};
            end
            `SDLC_OFF_STATUS: begin
                rdata_mux = {16'h0000, ~lane_rx_eq_en_reg};
            end
            default: begin
                rdata_mux = `SDLC_WORD_ZERO;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            hrdata_reg <= `SDLC_WORD_ZERO;
        end else if (state_reg == ST_WAIT2) begin
            hrdata_reg <= rdata_mux;
        end
    end

    // Lane select and port configuration are ordinary, not sticky
    always @(posedge clk_sys) begin
        if (!resetn) begin
            lane_select_reg <= `SDLC_XC_RESET;
            port_cfg_reg    <= `SDLC_PC_RESET;
        end else begin
            if (wr_xc) begin
                lane_select_reg <= hwdata[`SDLC_XC_LANE_SEL];
            end
            if (wr_pc) begin
                port_cfg_reg <= hwdata[`SDLC_PC_W-1:0];
            end
        end
    end

    assign deemph_6db = (port_cfg_reg[`SDLC_PC_DEEMPH_SEL] == `SDLC_DEEMPH_6DB);
    assign low_swing  = (port_cfg_reg[`SDLC_PC_LOW_SWING] == `SDLC_LSE_ON);
    assign gen2       = port_cfg_reg[`SDLC_PC_GEN2];

    // Lane drivers, each from its own entry
    genvar g;
    generate
        for (g = 0; g < `SDLC_LANES; g = g + 1) begin : g_drv
            wire [`SDLC_ENT_W-1:0] ent;
            assign ent = all_q[g*`SDLC_ENT_W +: `SDLC_ENT_W];
            always @(posedge clk_sys) begin
                if (!sticky_resetn) begin
                    lane_ls_level_reg[g*4 +: 4]        <= 4'h0;
                    lane_ls_use_reg[g]                 <= 1'b0;
                    lane_fine_deemph_reg[g*3 +: 3]     <= 3'h0;
                    lane_fine_deemph_use_reg[g]        <= 1'b0;
                    lane_rx_eq_zero_reg[g*3 +: 3]      <= 3'h0;
                    lane_rx_eq_boost_reg[g*3 +: 3]     <= 3'h0;
                    lane_rx_eq_en_reg[g]               <= 1'b0;
                end else begin
                    lane_ls_level_reg[g*4 +: 4] <= gen2 ?
                        ent[`SDLC_ENT_LSG2] : ent[`SDLC_ENT_LSG1];
                    lane_ls_use_reg[g] <= low_swing;
                    lane_fine_deemph_reg[g*3 +: 3] <= ent[`SDLC_ENT_FINE];
                    // Only -6.0dB at Gen 2 in full swing; low swing has
                    // no de-emphasis at all
                    lane_fine_deemph_use_reg[g] <= deemph_6db && gen2 &&
                                                   !low_swing;
                    // Codes pass straight through, the analog side scales
                    lane_rx_eq_zero_reg[g*3 +: 3]  <= ent[`SDLC_ENT_ZERO];
                    lane_rx_eq_boost_reg[g*3 +: 3] <= ent[`SDLC_ENT_BOOST];
                    lane_rx_eq_en_reg[g] <=
                        (ent[`SDLC_ENT_ZERO] != `SDLC_EQ_OFF_CODE) ||
                        (ent[`SDLC_ENT_BOOST] != `SDLC_EQ_OFF_CODE);
                end
            end
        end
    endgenerate

endmodule // sdlc_top
`default_nettype wire

// ===== hw/sdlc_consts.vh
// Constants for the transceiver lane analog control register bank
//
// Overview of operation
// - Fine de-emphasis for -6.0dB full-swing Gen 2: bits 23:21, reset 0x2
// - Fine de-emphasis is ignored whenever the port runs in low-swing mode
// - Low-swing Gen 1 level: bits 27:24, reset 0x9, used at Gen 1
// - Low-swing Gen 2 level: bits 31:28, reset 0x8, used at Gen 2
// - Transmit field writes update only the lane chosen by lane select
// - Every lane copy is software-sticky, kept across ordinary resets
// - Equalizer zero: bits 2:0, reset 0x1, higher code gives more gain
// - Equalizer boost: bits 5:3, reset 0x7, higher code gives more boost
// - Zero and boost both zero turns lane equalization off
// - Equalizer writes update only the lane chosen by lane select
// - De-emphasis select picks -3.5dB or -6.0dB field set for Gen 2
`ifndef SDLC_CONSTS_VH
`define SDLC_CONSTS_VH

// Lanes and lane entry layout
`define SDLC_LANES          16
`define SDLC_LANE_W         4
`define SDLC_ENT_W          17
`define SDLC_ENT_LSG2       16:13
`define SDLC_ENT_LSG1       12:9
`define SDLC_ENT_FINE       8:6
`define SDLC_ENT_BOOST      5:3
`define SDLC_ENT_ZERO       2:0
`define SDLC_ENT_TX         16:6
`define SDLC_ENT_RX         5:0
`define SDLC_ENT_RESET      17'h112B9

// Register byte offsets, decoded on the low address bits
`define SDLC_ADDR_W         8
`define SDLC_OFF_TX_DRIVE   8'h00
`define SDLC_OFF_RX_EQ      8'h04
`define SDLC_OFF_XCVR_CTL   8'h08
`define SDLC_OFF_PORT_CFG   8'h0C
`define SDLC_OFF_STATUS     8'h10

// Transmit drive register fields
`define SDLC_TX_FINE        23:21
`define SDLC_TX_LSG1        27:24
`define SDLC_TX_LSG2        31:28
`define SDLC_TX_HELD        31:21
`define SDLC_TX_LOW_ZERO    21'h00000

// Receiver equalizer register fields
`define SDLC_RX_ZERO        2:0
`define SDLC_RX_BOOST       5:3
`define SDLC_RX_HELD        5:0
`define SDLC_RX_HIGH_ZERO   26'h000000
`define SDLC_EQ_OFF_CODE    3'h0

// Transceiver control and port configuration fields
`define SDLC_XC_LANE_SEL    3:0
`define SDLC_XC_RESET       4'h0
`define SDLC_PC_DEEMPH_SEL  0
`define SDLC_PC_LOW_SWING   1
`define SDLC_PC_GEN2        2
`define SDLC_PC_W           3
`define SDLC_PC_RESET       3'h0
`define SDLC_DEEMPH_6DB     1'b1
`define SDLC_LSE_ON         1'b1

// AHB-Lite codes
`define SDLC_HTRANS_NONSEQ  2'h2
`define SDLC_HRESP_OKAY     1'b0
`define SDLC_WORD_ZERO      32'h00000000

`endif

// ===== hw/sdlc_lane_mem.v
// Per-lane storage of transmit and equalizer fields, one entry per lane
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_consts.vh"

module sdlc_lane_mem (
    // Clock and sticky reset
    input  wire                                 clk_sys,
    input  wire                                 sticky_resetn,
    // Write port
    input  wire [`SDLC_LANE_W-1:0]              wr_lane,
    input  wire                                 wr_tx,
    input  wire                                 wr_rx,
    input  wire [`SDLC_ENT_W-1:0]               wr_data,
    // Registered read port
    input  wire [`SDLC_LANE_W-1:0]              rd_lane,
    output reg  [`SDLC_ENT_W-1:0]               rd_data_reg,
    // All entries in parallel for the lane drivers
    output wire [`SDLC_LANES*`SDLC_ENT_W-1:0]   all_q
);

    reg [`SDLC_ENT_W-1:0] ent_reg [0:`SDLC_LANES-1];

    genvar g;
    generate
        for (g = 0; g < `SDLC_LANES; g = g + 1) begin : g_lane
            // Only the sticky reset reaches here, hot resets leave it alone
            always @(posedge clk_sys) begin
                if (!sticky_resetn) begin
                    ent_reg[g] <= `SDLC_ENT_RESET;
                end else begin
                    if (wr_tx && (wr_lane == g)) begin
                        ent_reg[g][`SDLC_ENT_TX] <= wr_data[`SDLC_ENT_TX];
                    end
                    if (wr_rx && (wr_lane == g)) begin
                        ent_reg[g][`SDLC_ENT_RX] <= wr_data[`SDLC_ENT_RX];
                    end
                end
            end
            assign all_q[g*`SDLC_ENT_W +: `SDLC_ENT_W] = ent_reg[g];
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (!sticky_resetn) begin
            rd_data_reg <= `SDLC_ENT_RESET;
        end else begin
            rd_data_reg <= ent_reg[rd_lane];
        end
    end

endmodule // sdlc_lane_mem
`default_nettype wire

// ===== tb/sdlc_top_sva.sv
// Bus timing and lane output checks for the lane analog control bank
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_consts.vh"

module sdlc_top_sva (
    // Clock and resets
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        sticky_resetn,
    // Bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata_reg,
    input wire logic        hreadyout_reg,
    input wire logic        hresp_reg,
    // Lane outputs
    input wire logic [15:0] lane_ls_use_reg,
    input wire logic [15:0] lane_fine_deemph_use_reg,
    input wire logic [47:0] lane_rx_eq_zero_reg,
    input wire logic [47:0] lane_rx_eq_boost_reg,
    input wire logic [15:0] lane_rx_eq_en_reg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn || !sticky_resetn);

    logic        take;
    logic [15:0] eq_exp;
    assign take = hsel && hready && htrans == `SDLC_HTRANS_NONSEQ;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            eq_exp[i] = |{lane_rx_eq_zero_reg[3*i+:3],
                          lane_rx_eq_boost_reg[3*i+:3]};
        end
    end

    a_read_wait: assert property (take && !hwrite |=>
        !hreadyout_reg [*2] ##1 hreadyout_reg) else $error("read wait");
    a_write_nowait: assert property (take && hwrite |=>
        hreadyout_reg) else $error("write wait");
    a_wait_cause: assert property ($fell(hreadyout_reg) |->
        $past(take && !hwrite)) else $error("stray wait state");
    a_rdata_hold: assert property (!$stable(hrdata_reg) |->
        $rose(hreadyout_reg)) else $error("read data moved");
    a_resp_okay: assert property (hresp_reg == `SDLC_HRESP_OKAY)
        else $error("response not okay");
    a_eq_off: assert property (lane_rx_eq_en_reg == eq_exp)
        else $error("equalizer enable wrong");
    a_fine_lowswing: assert property ((lane_fine_deemph_use_reg &
        lane_ls_use_reg) == 16'h0000) else $error("fine used in low swing");
    a_mode_uniform: assert property (lane_fine_deemph_use_reg == 16'h0000
        || lane_fine_deemph_use_reg == 16'hFFFF) else $error("mode split");
    a_sticky_dflt: assert property ($rose(sticky_resetn) |=>
        lane_rx_eq_boost_reg == {16{3'h7}} &&
        lane_rx_eq_zero_reg == {16{3'h1}}) else $error("lane defaults");
endmodule // sdlc_top_sva

bind sdlc_top sdlc_top_sva u_sva (.clk_sys, .resetn, .sticky_resetn, .hsel,
    .htrans, .hwrite, .hready, .hrdata_reg, .hreadyout_reg, .hresp_reg,
    .lane_ls_use_reg, .lane_fine_deemph_use_reg, .lane_rx_eq_zero_reg,
    .lane_rx_eq_boost_reg, .lane_rx_eq_en_reg);
`default_nettype wire

// ===== tb/serdes_lane_analog_ctl_tb_top.sv
// Self-checking bench for the lane analog control register bank
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_consts.vh"

module serdes_lane_analog_ctl_tb_top;
    logic        clk_sys = 1'b0;
    logic        resetn, sticky_resetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata_reg, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout_reg, hresp_reg;
    logic [63:0] lvl;
    logic [15:0] ls_use, fd_use, eq_en;
    logic [47:0] fd, eq_z, eq_b;
    int          mismatches = 0;
    int          n_checks = 0;

    always #50 clk_sys = ~clk_sys;

    sdlc_top uut (.clk_sys(clk_sys), .resetn(resetn),
        .sticky_resetn(sticky_resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout_reg), .hrdata_reg(hrdata_reg),
        .hreadyout_reg(hreadyout_reg), .hresp_reg(hresp_reg),
        .lane_ls_level_reg(lvl), .lane_ls_use_reg(ls_use),
        .lane_fine_deemph_reg(fd), .lane_fine_deemph_use_reg(fd_use),
        .lane_rx_eq_zero_reg(eq_z), .lane_rx_eq_boost_reg(eq_b),
        .lane_rx_eq_en_reg(eq_en));

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single word transfer; hready is this slave's own hreadyout
    task automatic bus(input logic [7:0] a, input logic wr,
                       input logic [31:0] wd);
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= `SDLC_HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hreadyout_reg !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout_reg !== 1'b1);
        rd = hrdata_reg;
    endtask

    task automatic rdchk(input logic [7:0] a, input string nm,
                         input logic [31:0] exp);
        bus(a, 1'b0, 32'h00000000);
        chk(nm, rd, exp);
    endtask

    // Lane drivers lag the stored value by one more clock
    task automatic settle;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic t_defaults;
        rdchk(`SDLC_OFF_TX_DRIVE, "tx dflt", 32'h89400000);
        rdchk(`SDLC_OFF_RX_EQ, "rx dflt", 32'h00000039);
        chk("lvl dflt", {28'h0, lvl[3:0]}, 32'h9);
        chk("eq en dflt", {16'h0, eq_en}, 32'hFFFF);
    endtask

    task automatic t_steer;
        bus(`SDLC_OFF_XCVR_CTL, 1'b1, 32'h5);
        bus(`SDLC_OFF_TX_DRIVE, 1'b1, 32'hA5DFFFFF);
        bus(`SDLC_OFF_RX_EQ, 1'b1, 32'hFFFFFFEA);
        rdchk(`SDLC_OFF_TX_DRIVE, "tx lane5", 32'hA5C00000);
        rdchk(`SDLC_OFF_RX_EQ, "rx lane5", 32'h0000002A);
        settle;
        chk("zero5", {29'h0, eq_z[17:15]}, 32'h2);
        chk("boost5", {29'h0, eq_b[17:15]}, 32'h5);
        chk("zero4", {29'h0, eq_z[14:12]}, 32'h1);
        bus(`SDLC_OFF_XCVR_CTL, 1'b1, 32'h4);
        rdchk(`SDLC_OFF_TX_DRIVE, "tx lane4", 32'h89400000);
        rdchk(`SDLC_OFF_RX_EQ, "rx lane4", 32'h00000039);
    endtask

    // Config bits: 0 de-emphasis -6.0dB, 1 low swing, 2 second rate
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            bus(`SDLC_OFF_PORT_CFG, 1'b1, m);
            settle;
            chk("level5", lvl[23:20], m[2] ? 4'hA : 4'h5);
            chk("ls use", ls_use, m[1] ? 16'hFFFF : 16'h0000);
            chk("fine use5", fd_use[5], m == 5);
            chk("fine5", fd[17:15], 3'h6);
        end
        bus(`SDLC_OFF_PORT_CFG, 1'b1, 32'h0);
    endtask

    task automatic t_eq_off;
        bus(`SDLC_OFF_XCVR_CTL, 1'b1, 32'h5);
        bus(`SDLC_OFF_RX_EQ, 1'b1, 32'h0);
        settle;
        chk("eq en", {16'h0, eq_en}, 32'hFFDF);
        rdchk(`SDLC_OFF_STATUS, "eq off flags", 32'h00000020);
        bus(`SDLC_OFF_RX_EQ, 1'b1, 32'h8);
        settle;
        chk("eq en boost", eq_en[5], 1'b1);
        bus(`SDLC_OFF_STATUS, 1'b1, 32'hFFFFFFFF);
        rdchk(`SDLC_OFF_STATUS, "status ro", 32'h0);
        rdchk(8'h14, "unmapped", 32'h0);
    endtask

    // Ordinary reset keeps lane copies; only the sticky reset clears them
    task automatic t_sticky;
        resetn <= 1'b0;
        settle;
        resetn <= 1'b1;
        settle;
        rdchk(`SDLC_OFF_XCVR_CTL, "sel reset", 32'h0);
        bus(`SDLC_OFF_XCVR_CTL, 1'b1, 32'h5);
        rdchk(`SDLC_OFF_RX_EQ, "rx kept", 32'h00000008);
        rdchk(`SDLC_OFF_TX_DRIVE, "tx kept", 32'hA5C00000);
        sticky_resetn <= 1'b0;
        settle;
        sticky_resetn <= 1'b1;
        settle;
        rdchk(`SDLC_OFF_RX_EQ, "rx cleared", 32'h00000039);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        sticky_resetn = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        sticky_resetn <= 1'b1;
        settle;
        t_defaults;
        t_steer;
        t_modes;
        t_eq_off;
        t_sticky;
        summarize;
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        summarize;
    end
endmodule // serdes_lane_analog_ctl_tb_top
`default_nettype wire
